// *** rtl/frp_decoder.sv ***
// Flash range protection decoder: config register, range compare, events.
// Assumes the flash controller presents the stored byte after reset and
// drives its check request from logic on sys_clk.
//
// Notes on behaviour
// RULE1: Polarity 1: a cleared disable bit protects its selected range.
// RULE2: Polarity 0: a cleared disable bit makes its range unprotected.
// RULE3: High disable bit 0 enables the region at the top of flash.
// RULE4: Low disable bit 0 enables the region at the bottom of flash.
// RULE5: High size code picks 2, 4, 8 or 16 KB ending at FFFF.
// RULE6: Low size code picks 1, 2, 4 or 8 KB from 4000.
// RULE7: High size field writable only while high disable bit is 1.
// RULE8: Low size field writable only while low disable bit is 1.
// RULE9: Polarity 0 with both disable bits 1 protects the whole array.
// RULE10: Software keeps the spare bit 6 in its erased state.
// RULE11: Settings load from flash after reset, then software may change.
// RULE12: Polarity bit can only be written from 1 to 0.
// RULE13: Reset loads the config from the byte stored at FF0D.
// RULE14: Program or erase aimed at protected area raises violation.
// RULE15: Mass erase only with polarity and both disable bits set.
// RULE16: Combinational protected indication for any checked address.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module frp_decoder
    import frp_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] bus_addr,
    input  wire logic [7:0]        bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output logic      [7:0]        bus_rdata,
    output logic                   nv_load_req,
    output logic      [15:0]       nv_load_addr,
    input  wire logic [7:0]        nv_load_data,
    input  wire logic              nv_load_valid,
    input  wire logic              chk_valid,
    input  wire logic              chk_mass_erase,
    input  wire logic [15:0]       chk_addr,
    output logic                   chk_protected,
    output logic                   protection_violation_flag,
    output logic [7:0]             flash_protection_config,
    output logic                   irq
);
    frp_state_t state_reg;
    frp_state_t state_next;

    logic       protection_polarity_select;
    logic       high_range_disable;
    logic       low_range_disable;
    logic [1:0] high_range_size;
    logic [1:0] low_range_size;
    logic [15:0] hi_base;
    logic [15:0] lo_top;
    logic       in_high;
    logic       in_low;
    logic       sel_hit;
    logic       mass_ok;
    logic       ev_viol;
    logic       ev_mass;
    logic       wr_cfg;
    logic       rd_status;
    logic [FRP_EV_W-1:0] events;

    // Field view of the config register
    assign protection_polarity_select = state_reg.cfg[FRP_POL_BIT];
    assign high_range_disable         = state_reg.cfg[FRP_HDIS_BIT];
    assign low_range_disable          = state_reg.cfg[FRP_LDIS_BIT];
    assign high_range_size = state_reg.cfg[FRP_HS_LSB +: 2];
    assign low_range_size  = state_reg.cfg[FRP_LS_LSB +: 2];

    // Range bounds from the size codes
    always_comb begin
        unique case (high_range_size)
            2'h0: hi_base = FRP_HI_BASE0; // RULE5
            2'h1: hi_base = FRP_HI_BASE1;
            2'h2: hi_base = FRP_HI_BASE2;
            2'h3: hi_base = FRP_HI_BASE3;
        endcase
        unique case (low_range_size)
            2'h0: lo_top = FRP_LO_TOP0; // RULE6
            2'h1: lo_top = FRP_LO_TOP1;
            2'h2: lo_top = FRP_LO_TOP2;
            2'h3: lo_top = FRP_LO_TOP3;
        endcase
    end

    // Address comparison against each enabled region
    assign in_high = (chk_addr >= hi_base); // RULE5
    assign in_low  = (chk_addr >= FRP_LO_BASE) && (chk_addr <= lo_top);
    assign sel_hit = (!high_range_disable && in_high) // RULE3
                  || (!low_range_disable && in_low);  // RULE4

    // Protected decision; everything protected until the load is done
    always_comb begin
        if (state_reg.load_pending) begin
            chk_protected = 1'b1;
        end else if (protection_polarity_select) begin
            chk_protected = sel_hit; // RULE1 RULE16
        end else if (high_range_disable && low_range_disable) begin
            chk_protected = 1'b1; // RULE9
        end else begin
            chk_protected = !sel_hit; // RULE2
        end
    end

    // Mass erase needs protection fully open
    assign mass_ok = !state_reg.load_pending && protection_polarity_select
                  && high_range_disable && low_range_disable; // RULE15

    // Violation events toward the command controller
    assign ev_viol = chk_valid && !chk_mass_erase && chk_protected; // RULE14
    assign ev_mass = chk_valid && chk_mass_erase && !mass_ok; // RULE15
    assign protection_violation_flag = ev_viol || ev_mass;
    assign events = {ev_mass, ev_viol};

    // Bus decode
    assign wr_cfg = bus_wr && (bus_addr == ADDR_W'(FRP_OFS_CONFIG))
                 && !state_reg.load_pending;
    assign rd_status = bus_rd && (bus_addr == ADDR_W'(FRP_OFS_STATUS));

    // Next state
    always_comb begin
        state_next = state_reg;
        // Stored byte capture after reset
        if (state_reg.load_pending && nv_load_valid) begin
            state_next.cfg = nv_load_data; // RULE13 RULE11
            state_next.load_pending = 1'b0;
        end
        // Software update of the config register
        if (wr_cfg) begin
            state_next.cfg[FRP_POL_BIT] = protection_polarity_select
                                       && bus_wdata[FRP_POL_BIT]; // RULE12
            state_next.cfg[FRP_HDIS_BIT] = bus_wdata[FRP_HDIS_BIT];
            state_next.cfg[FRP_LDIS_BIT] = bus_wdata[FRP_LDIS_BIT];
            if (high_range_disable) begin
                state_next.cfg[FRP_HS_LSB +: 2] =
                    bus_wdata[FRP_HS_LSB +: 2]; // RULE7
            end
            if (low_range_disable) begin
                state_next.cfg[FRP_LS_LSB +: 2] =
                    bus_wdata[FRP_LS_LSB +: 2]; // RULE8
            end
        end
        // Mask register
        if (bus_wr && (bus_addr == ADDR_W'(FRP_OFS_MASK))) begin
            state_next.mask = bus_wdata[FRP_EV_W-1:0];
        end
        // Sticky status, read clears, a new event wins
        state_next.status = (rd_status ? '0 : state_reg.status) | events;
        // Read data stands only in the cycle after the strobe
        state_next.rdata = 8'h00;
        if (bus_rd) begin
            unique case (bus_addr)
                ADDR_W'(FRP_OFS_CONFIG): state_next.rdata = state_reg.cfg;
                ADDR_W'(FRP_OFS_STATUS):
                    state_next.rdata = {6'h00, state_reg.status};
                ADDR_W'(FRP_OFS_MASK):
                    state_next.rdata = {6'h00, state_reg.mask};
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg.cfg          <= FRP_CONFIG_RST;
            state_reg.load_pending <= 1'b1;
            state_reg.status       <= FRP_STATUS_RST;
            state_reg.mask         <= FRP_MASK_RST;
            state_reg.rdata        <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs
    assign bus_rdata = state_reg.rdata;
    assign nv_load_req = state_reg.load_pending;
    assign nv_load_addr = FRP_NV_ADDR; // RULE13
    assign flash_protection_config = state_reg.cfg;
    assign irq = |(state_reg.status & state_reg.mask);

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence load_done_s;
        state_reg.load_pending && nv_load_valid;
    endsequence

    sequence cfg_loaded_s;
        !state_reg.load_pending && (state_reg.cfg == $past(nv_load_data));
    endsequence

    reset_load_a: assert property ( // RULE13
        load_done_s |=> cfg_loaded_s)
        else $error("stored byte not loaded");

    polarity_once_a: assert property ( // RULE12
        !state_reg.load_pending && !protection_polarity_select
        |=> !protection_polarity_select)
        else $error("polarity rose from 0 to 1");

    high_size_lock_a: assert property ( // RULE7
        !state_reg.load_pending && !high_range_disable
        |=> $stable(high_range_size))
        else $error("high size changed while enabled");

    low_size_lock_a: assert property ( // RULE8
        !state_reg.load_pending && !low_range_disable
        |=> $stable(low_range_size))
        else $error("low size changed while enabled");

    full_protect_a: assert property ( // RULE9
        !state_reg.load_pending && !protection_polarity_select
        && high_range_disable && low_range_disable |-> chk_protected)
        else $error("array not fully protected");

    open_none_a: assert property ( // RULE1
        mass_ok |-> !chk_protected)
        else $error("protection reported while fully open");

    high_edge_a: assert property ( // RULE5
        !state_reg.load_pending && protection_polarity_select
        && !high_range_disable && low_range_disable
        |-> chk_protected == (chk_addr >= ((high_range_size == 2'h0)
            ? FRP_HI_BASE0 : (high_range_size == 2'h1) ? FRP_HI_BASE1
            : (high_range_size == 2'h2) ? FRP_HI_BASE2 : FRP_HI_BASE3)))
        else $error("high range bound wrong");

    low_unprot_a: assert property ( // RULE2
        !state_reg.load_pending && !protection_polarity_select
        && high_range_disable && !low_range_disable
        |-> chk_protected == !((chk_addr >= FRP_LO_BASE)
            && (chk_addr <= ((low_range_size == 2'h0) ? FRP_LO_TOP0
            : (low_range_size == 2'h1) ? FRP_LO_TOP1
            : (low_range_size == 2'h2) ? FRP_LO_TOP2 : FRP_LO_TOP3))))
        else $error("low exception range wrong");

    low_edge_a: assert property ( // RULE6
        !state_reg.load_pending && protection_polarity_select
        && high_range_disable && !low_range_disable
        |-> chk_protected == ((chk_addr >= FRP_LO_BASE)
            && (chk_addr <= ((low_range_size == 2'h0) ? FRP_LO_TOP0
            : (low_range_size == 2'h1) ? FRP_LO_TOP1
            : (low_range_size == 2'h2) ? FRP_LO_TOP2 : FRP_LO_TOP3))))
        else $error("low range bound wrong");

    viol_sticky_a: assert property ( // RULE14
        ev_viol |=> state_reg.status[FRP_EV_VIOL] ##1
        (state_reg.status[FRP_EV_VIOL] || $past(rd_status)))
        else $error("violation not kept");

    mass_refuse_a: assert property ( // RULE15
        chk_valid && chk_mass_erase && !mass_ok
        |-> protection_violation_flag)
        else $error("mass erase not refused");

    load_hold_a: assert property ( // RULE11
        state_reg.load_pending |-> chk_protected && nv_load_req)
        else $error("not protected while loading");

    // Size bits of the write, seen one cycle later by the size checks
    logic [1:0] wr_hs;
    logic [1:0] wr_ls;
    assign wr_hs = bus_wdata[FRP_HS_LSB +: 2];
    assign wr_ls = bus_wdata[FRP_LS_LSB +: 2];

    high_size_open_a: assert property ( // RULE7
        wr_cfg && high_range_disable |=> high_range_size == $past(wr_hs))
        else $error("high size write lost");

    low_size_open_a: assert property ( // RULE8
        wr_cfg && low_range_disable |=> low_range_size == $past(wr_ls))
        else $error("low size write lost");

    // Spare bit keeps its loaded value; the bus cannot reach it
    spare_keep_a: assert property (
        !state_reg.load_pending |=> $stable(state_reg.cfg[FRP_SPARE_BIT]))
        else $error("spare bit changed");

    // Read clears the violation bit unless a new one lands
    status_clear_a: assert property ( // RULE14
        rd_status && !ev_viol |=> !state_reg.status[FRP_EV_VIOL])
        else $error("violation not cleared by read");

    mass_allow_a: assert property ( // RULE15
        chk_valid && chk_mass_erase && mass_ok |-> !protection_violation_flag)
        else $error("open mass erase refused");

    // Read data is zero outside the cycle after a read strobe
    read_window_a: assert property (
        !bus_rd |=> bus_rdata == 8'h00)
        else $error("read data outside its cycle");

    irq_level_a: assert property (
        irq == |(state_reg.status & state_reg.mask))
        else $error("interrupt level wrong");
endmodule // frp_decoder

// *** rtl/frp_pkg.sv ***
// Package of the flash range protection decoder: offsets, fields, resets.
// Assumes an 8-bit register port and a 16-bit flash address map.
package frp_pkg;
    // Register offsets on the register port
    localparam logic [3:0]  FRP_OFS_CONFIG = 4'h0;
    localparam logic [3:0]  FRP_OFS_STATUS = 4'h1;
    localparam logic [3:0]  FRP_OFS_MASK   = 4'h2;

    // Field positions of flash_protection_config
    localparam int FRP_POL_BIT   = 7;
    localparam int FRP_SPARE_BIT = 6;
    localparam int FRP_HDIS_BIT  = 5;
    localparam int FRP_HS_LSB    = 3;
    localparam int FRP_LDIS_BIT  = 2;
    localparam int FRP_LS_LSB    = 0;

    // Status and mask bit positions
    localparam int FRP_EV_VIOL = 0;
    localparam int FRP_EV_MASS = 1;
    localparam int FRP_EV_W    = 2;

    // Reset values: fully protected until the stored byte is loaded
    localparam logic [7:0]          FRP_CONFIG_RST = 8'h7F;
    localparam logic [FRP_EV_W-1:0] FRP_STATUS_RST = 2'h0;
    localparam logic [FRP_EV_W-1:0] FRP_MASK_RST   = 2'h0;

    // Flash location of the stored protection byte
    localparam logic [15:0] FRP_NV_ADDR = 16'hFF0D;

    // High range lower bounds by size code; upper bound is the map top
    localparam logic [15:0] FRP_HI_BASE0 = 16'hF800;
    localparam logic [15:0] FRP_HI_BASE1 = 16'hF000;
    localparam logic [15:0] FRP_HI_BASE2 = 16'hE000;
    localparam logic [15:0] FRP_HI_BASE3 = 16'hC000;

    // Low range fixed base and upper bounds by size code
    localparam logic [15:0] FRP_LO_BASE = 16'h4000;
    localparam logic [15:0] FRP_LO_TOP0 = 16'h43FF;
    localparam logic [15:0] FRP_LO_TOP1 = 16'h47FF;
    localparam logic [15:0] FRP_LO_TOP2 = 16'h4FFF;
    localparam logic [15:0] FRP_LO_TOP3 = 16'h5FFF;

    // Whole state of the decoder
    typedef struct packed {
        logic [7:0]          cfg;
        logic                load_pending;
        logic [FRP_EV_W-1:0] status;
        logic [FRP_EV_W-1:0] mask;
        logic [7:0]          rdata;
    } frp_state_t;
endpackage : frp_pkg

// *** verification/flash_range_protection_decoder_test.sv ***
// Bench of the range decoder: load, write guard, mass erase, status and
// interrupt cases, then decode table rows.
// Assumes frp_pkg and the flash model beside it; 50 MHz clock.
`timescale 1ns/1ps
module flash_range_protection_decoder_test
    import frp_pkg::*;
;
    typedef struct {
        logic [7:0]  cfg;
        logic [15:0] a;
        logic        p;
    } frp_case_t;

    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  bus_addr = 4'h0;
    logic [7:0]  bus_wdata = 8'h00;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic        chk_valid = 1'b0;
    logic        chk_mass_erase = 1'b0;
    logic [15:0] chk_addr = 16'h0000;
    logic [7:0]  stored_byte = 8'hFF;
    logic [3:0]  load_delay = 4'h4;
    logic [7:0]  bus_rdata, nv_load_data, flash_protection_config;
    logic [15:0] nv_load_addr;
    logic        nv_load_req, nv_load_valid, chk_protected, irq;
    logic        protection_violation_flag;
    int          fail_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    // Spare bit 6 stays erased in every stored byte
    frp_case_t rows [25] = '{
        '{8'hFF, 16'hF000, 1'b0}, '{8'hC7, 16'hF800, 1'b1},
        '{8'hC7, 16'hF7FF, 1'b0}, '{8'hCF, 16'hF000, 1'b1},
        '{8'hCF, 16'hEFFF, 1'b0}, '{8'hD7, 16'hE000, 1'b1},
        '{8'hD7, 16'hDFFF, 1'b0}, '{8'hDF, 16'hC000, 1'b1},
        '{8'hDF, 16'hBFFF, 1'b0}, '{8'hE0, 16'h43FF, 1'b1},
        '{8'hE0, 16'h4400, 1'b0}, '{8'hE1, 16'h47FF, 1'b1},
        '{8'hE1, 16'h4800, 1'b0}, '{8'hE2, 16'h4FFF, 1'b1},
        '{8'hE2, 16'h5000, 1'b0}, '{8'hE3, 16'h5FFF, 1'b1},
        '{8'hE3, 16'h6000, 1'b0}, '{8'hE3, 16'h3FFF, 1'b0},
        '{8'h7F, 16'h0000, 1'b1}, '{8'h47, 16'hF800, 1'b0},
        '{8'h47, 16'h8000, 1'b1}, '{8'h78, 16'h4000, 1'b0},
        '{8'h78, 16'h4400, 1'b1}, '{8'hC0, 16'h4000, 1'b1},
        '{8'hC0, 16'h8000, 1'b0}};

    frp_decoder #(.ADDR_W(4)) uut (.sys_clk(sys_clk), .srst(srst),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .nv_load_req(nv_load_req),
        .nv_load_addr(nv_load_addr), .nv_load_data(nv_load_data),
        .nv_load_valid(nv_load_valid), .chk_valid(chk_valid),
        .chk_mass_erase(chk_mass_erase), .chk_addr(chk_addr),
        .chk_protected(chk_protected), .irq(irq),
        .protection_violation_flag(protection_violation_flag),
        .flash_protection_config(flash_protection_config));
    frp_flash_model flash_ctl (.sys_clk(sys_clk), .srst(srst),
        .nv_load_req(nv_load_req), .nv_load_addr(nv_load_addr),
        .stored_byte(stored_byte), .load_delay(load_delay),
        .nv_load_data(nv_load_data), .nv_load_valid(nv_load_valid));

    // Clock and hang guard
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    // Read strobe, then compare data in the following cycle
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 check(16'(bus_rdata), 16'(e));
    endtask

    task automatic probe(input logic [15:0] a, input logic m, input logic f);
        @(posedge sys_clk);
        chk_valid      <= 1'b1;
        chk_addr       <= a;
        chk_mass_erase <= m;
        #1 check(16'(protection_violation_flag), 16'(f));
        @(posedge sys_clk);
        chk_valid <= 1'b0;
    endtask

    task automatic wait_load();
        int n;
        n = 0;
        while (nv_load_req !== 1'b0 && n < 20) begin
            @(posedge sys_clk) #1;
            n++;
        end
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        // Reset, slow load, write ignored while loading
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk) #1;
        check(16'(flash_protection_config), 16'(FRP_CONFIG_RST));
        check(16'(chk_protected), 16'h1);
        check(nv_load_addr, FRP_NV_ADDR);
        check(16'(nv_load_req), 16'h1);
        wr(FRP_OFS_CONFIG, 8'h40);
        wait_load();
        rdc(FRP_OFS_CONFIG, 8'hFF);
        check(16'(nv_load_req), 16'h0);
        // Size fields guarded by their disable bits
        probe(16'h8000, 1'b1, 1'b0);
        wr(FRP_OFS_CONFIG, 8'hE0);
        rdc(FRP_OFS_CONFIG, 8'hE0);
        wr(FRP_OFS_CONFIG, 8'hFF);
        rdc(FRP_OFS_CONFIG, 8'hFC);
        wr(FRP_OFS_CONFIG, 8'hDF);
        rdc(FRP_OFS_CONFIG, 8'hDF);
        wr(FRP_OFS_CONFIG, 8'hC7);
        rdc(FRP_OFS_CONFIG, 8'hDF);
        probe(16'h8000, 1'b1, 1'b1);
        rdc(FRP_OFS_STATUS, 8'h02);
        // Polarity one way only
        wr(FRP_OFS_CONFIG, 8'h7F);
        rdc(FRP_OFS_CONFIG, 8'h7F);
        wr(FRP_OFS_CONFIG, 8'hFF);
        rdc(FRP_OFS_CONFIG, 8'h7F);
        // Violation event, interrupt unmasked then masked
        wr(FRP_OFS_MASK, 8'h01);
        rdc(FRP_OFS_MASK, 8'h01);
        probe(16'h1234, 1'b0, 1'b1);
        #1 check(16'(irq), 16'h1);
        rdc(FRP_OFS_STATUS, 8'h01);
        check(16'(irq), 16'h0);
        wr(FRP_OFS_MASK, 8'h00);
        probe(16'h1234, 1'b0, 1'b1);
        #1 check(16'(irq), 16'h0);
        rdc(FRP_OFS_STATUS, 8'h01);
        wr(4'h7, 8'hAA);
        rdc(4'h7, 8'h00);
        rdc(FRP_OFS_CONFIG, 8'h7F);
        // Decode table: each row boots from its stored byte
        foreach (rows[i]) begin
            @(posedge sys_clk);
            stored_byte <= rows[i].cfg;
            load_delay  <= 4'(i % 3);
            srst        <= 1'b1;
            repeat (2) @(posedge sys_clk);
            srst <= 1'b0;
            @(posedge sys_clk) #1;
            wait_load();
            check(16'(flash_protection_config), 16'(rows[i].cfg));
            probe(rows[i].a, 1'b0, rows[i].p);
            #1 check(16'(chk_protected), 16'(rows[i].p));
        end
        tally_and_finish();
    end
endmodule // flash_range_protection_decoder_test

// *** verification/frp_flash_model.sv ***
// Flash side model: answers the decoder's request for the stored byte.
// Assumes the decoder holds its load request high until the byte is taken.
`timescale 1ns/1ps
module frp_flash_model
    import frp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       nv_load_req,
    input  wire logic [15:0] nv_load_addr,
    input  wire logic [7:0] stored_byte,
    input  wire logic [3:0] load_delay,
    output logic      [7:0] nv_load_data,
    output logic            nv_load_valid
);
    logic [3:0] wait_reg;

    // Cycles spent waiting on a pending load, saturating
    always_ff @(posedge sys_clk) begin
        if (srst || !nv_load_req) begin
            wait_reg <= 4'h0;
        end else if (wait_reg != 4'hF) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end

    // One valid cycle after the chosen delay; wrong address gets junk
    assign nv_load_valid = nv_load_req && !srst
                           && (wait_reg == load_delay);
    assign nv_load_data  = (nv_load_valid && nv_load_addr == FRP_NV_ADDR)
                           ? stored_byte : ~stored_byte;
endmodule // frp_flash_model
